// file: i2c_event_pkg.sv
// constants for the two-wire event, interrupt and dma request logic
package i2c_event_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_STATUS_ONE = 4'h0;
  localparam logic [3:0] OFS_STATUS_TWO = 4'h1;
  localparam logic [3:0] OFS_DATA       = 4'h2;
  localparam logic [3:0] OFS_CONTROL    = 4'h3;
  localparam logic [3:0] OFS_VECTOR     = 4'h4;
  localparam logic [3:0] OFS_PRIO_PEND  = 4'h5;
  localparam logic [3:0] OFS_MASK       = 4'h6;
  localparam logic [3:0] OFS_RX_COUNT   = 4'h7;
  localparam logic [3:0] OFS_TX_COUNT   = 4'h8;
  localparam logic [3:0] OFS_RX_ADDR    = 4'h9;
  localparam logic [3:0] OFS_TX_ADDR    = 4'hA;
  // status one bit positions
  localparam int S1_EVENT = 7;
  localparam int S1_HEADER = 6;
  localparam int S1_SENDING = 5;
  localparam int S1_BYTE = 3;
  localparam int S1_START = 1;
  localparam int S1_ADDRM = 0;
  // status two bit positions
  localparam int S2_ADDRTX = 5;
  localparam int S2_NOACK = 4;
  localparam int S2_HALT = 3;
  localparam int S2_ARB = 2;
  localparam int S2_BUSERR = 1;
  localparam int S2_CLKLOW = 0;
  // control bit positions
  localparam int CR_ACK = 2;
  localparam int CR_STOP = 1;
  localparam int CR_ITE = 0;
  // priority/pending register positions
  localparam int PP_HOLD = 7;
  localparam int PP_ERRP = 6;
  localparam int PP_RXP = 5;
  localparam int PP_TXP = 4;
  // mask register positions
  localparam int MK_RXDMA = 7;
  localparam int MK_TXDMA = 6;
  localparam int MK_REOB = 5;
  localparam int MK_TEOB = 4;
  localparam int MK_ERRM = 2;
  localparam int MK_RXM = 1;
  localparam int MK_TXM = 0;
  // reset values
  localparam logic [7:0] RESET_PRIO_PEND = 8'h87;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  // hardware vector low bits and the priority level that turns requests off
  localparam logic [2:0] VEC_ERROR = 3'h2;
  localparam logic [2:0] VEC_RX = 3'h4;
  localparam logic [2:0] VEC_TX = 3'h6;
  localparam logic [2:0] PRIO_OFF = 3'h7;
  // transaction limits
  localparam logic [16:0] MAX_REGFILE = 17'h000DE;
  localparam logic [16:0] MAX_MEMORY = 17'h10000;
  // two-phase clear sequence states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_READ = 2'b01
  } clear_seq_type;
endpackage : i2c_event_pkg

// file: i2c_event_irq_dma_logic.sv
// event flags, interrupt sources, vectors and dma request logic
// What this block does
// - address match sets summary and match flags; status-one read clears them
// - received byte sets byte-done; status-one then data read, or dma, clears
// - byte to send sets byte-done; status-one then data write, or dma, clears
// - slave no-ack sets flags; release by stop pulse hides next halt event
// - slave stop sets halt flag; status-two read clears it
// - start sent sets start flag; status-one read then data write clears
// - address sent sets flag; status-one read then control write clears
// - header sent sets flag; status-one read then data write clears
// - byte-done with sending clear is rx source, with sending set tx source
// - dma in a direction suppresses its data interrupt, vector signals block end
// - error source raised by any error-type event flag
// - vector is five programmed bits plus three hardware bits 010/100/110
// - priority zero highest, all ones never served so request is off
// - internal order error, receive, transmit; block ends share data slots
// - source events set pending; request only when masked in and priority ok
// - pending and mask set keep the request up continuously, error request only with global enable
// - error pending forced high while any error flag is set
// - hold bit clear lets dma outrank; set with error pending pauses dma
// - counts limited to 222 register file or 65536 memory transactions
// - each transfer increments address and decrements counter
// - counter at zero raises block end pending, ignores global enable
// - global enable needed for flag interrupts; summary excludes block end
module i2c_event_irq_dma_logic (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  // bus events from the shifter, one-cycle pulses, and the sending-side level
  input  wire logic       evAddrMatch,
  input  wire logic       evByteRx,
  input  wire logic       evByteTx,
  input  wire logic       evNoAck,
  input  wire logic       evHalt,
  input  wire logic       evStartSent,
  input  wire logic       evAddrSent,
  input  wire logic       evHeaderSent,
  input  wire logic       evArbLost,
  input  wire logic       evBusError,
  input  wire logic       evClockLow,
  input  wire logic       sendingSide,
  // dma channel side
  input  wire logic       dmaRxDone,
  input  wire logic       dmaTxDone,
  input  wire logic       rxRegFile,
  input  wire logic       txRegFile,
  output logic            dmaRxReq,
  output logic            dmaTxReq,
  output logic      [7:0] dataOut,
  input  wire logic [7:0] dataIn,
  // interrupt side
  output logic            irqReq,
  output logic      [7:0] irqVector,
  output logic      [2:0] irqLevel
);
  // status and control storage
  logic [7:0] control;
  logic [7:0] vectorHigh;
  logic [7:0] prioPend;
  logic [7:0] mask;
  logic [7:0] dataReg;
  logic [16:0] rxCount;
  logic [16:0] txCount;
  logic [15:0] rxAddr;
  logic [15:0] txAddr;
  logic addrMatch, byteDone, noAck, halt, startSent, addrSent, headerSent;
  logic arbLost, busError, clockLow, sending, hideHalt, stopPrev;
  i2c_event_pkg::clear_seq_type seq;
  logic [7:0] rdata;

  // access decode
  wire rdS1 = regRead && regAddr == i2c_event_pkg::OFS_STATUS_ONE;
  wire rdS2 = regRead && regAddr == i2c_event_pkg::OFS_STATUS_TWO;
  wire rdDr = regRead && regAddr == i2c_event_pkg::OFS_DATA;
  wire wrDr = regWrite && regAddr == i2c_event_pkg::OFS_DATA;
  wire wrCr = regWrite && regAddr == i2c_event_pkg::OFS_CONTROL;
  wire wrPp = regWrite && regAddr == i2c_event_pkg::OFS_PRIO_PEND;
  wire wrMk = regWrite && regAddr == i2c_event_pkg::OFS_MASK;
  wire armed = seq == i2c_event_pkg::SEQ_READ;
  // line release: stop bit written low after being high
  wire release_ = wrCr && stopPrev && !regWdata[i2c_event_pkg::CR_STOP];
  wire dmaDone = dmaRxDone || dmaTxDone;

  wire summary = addrMatch | byteDone | noAck | halt | startSent | addrSent | headerSent |
                 arbLost | busError | clockLow;
  wire errFlags = addrMatch | startSent | noAck | halt | arbLost | busError | headerSent |
                  addrSent | clockLow;
  wire rxSource = byteDone && !sending;
  wire txSource = byteDone && sending;
  wire rxIrqEv = rxSource && !mask[i2c_event_pkg::MK_RXDMA];
  wire txIrqEv = txSource && !mask[i2c_event_pkg::MK_TXDMA];
  wire irq_global_enable = control[i2c_event_pkg::CR_ITE];

  // status-one read arms the second access of a clear sequence
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq <= i2c_event_pkg::SEQ_IDLE;
    end else if (rdS1) begin
      seq <= i2c_event_pkg::SEQ_READ;
    end else if (rdDr || wrDr || wrCr) begin
      seq <= i2c_event_pkg::SEQ_IDLE;
    end
  end

  // event flags: set wins over clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addrMatch <= 1'b0;
      byteDone <= 1'b0;
      noAck <= 1'b0;
      halt <= 1'b0;
      startSent <= 1'b0;
      addrSent <= 1'b0;
      headerSent <= 1'b0;
      arbLost <= 1'b0;
      busError <= 1'b0;
      clockLow <= 1'b0;
      sending <= 1'b0;
      hideHalt <= 1'b0;
      stopPrev <= 1'b0;
    end else begin
      sending <= sendingSide;
      if (wrCr) begin
        stopPrev <= regWdata[i2c_event_pkg::CR_STOP];
      end
      addrMatch <= evAddrMatch || (addrMatch && !rdS1);
      byteDone <= evByteRx || evByteTx || evNoAck ||
                  (byteDone && !(armed && (rdDr || wrDr)) && !dmaDone && !release_ && !(noAck && wrDr));
      noAck <= evNoAck || (noAck && !rdS1);
      // a release hides the following halt event
      hideHalt <= release_ || (hideHalt && !evHalt && !evStartSent);
      halt <= (evHalt && !hideHalt) || (halt && !rdS2);
      startSent <= evStartSent || (startSent && !(armed && wrDr));
      addrSent <= evAddrSent || (addrSent && !(armed && wrCr));
      headerSent <= evHeaderSent || (headerSent && !(armed && wrDr));
      arbLost <= evArbLost || (arbLost && !rdS2);
      busError <= evBusError || (busError && !rdS2);
      clockLow <= evClockLow || (clockLow && !rdS2);
    end
  end

  // software registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control <= i2c_event_pkg::RESET_ZERO;
      vectorHigh <= i2c_event_pkg::RESET_ZERO;
      dataReg <= i2c_event_pkg::RESET_ZERO;
    end else begin
      if (wrCr) begin
        control <= regWdata;
      end
      if (regWrite && regAddr == i2c_event_pkg::OFS_VECTOR) begin
        vectorHigh <= {regWdata[7:3], 3'h0};
      end
      if (wrDr) begin
        dataReg <= regWdata;
      end else if (dmaRxReq) begin
        dataReg <= dataIn;
      end
    end
  end

  // pending bits: hardware set beats software clear
  // error pending follows the flags even without the global enable
  wire setErr = errFlags;
  wire setRx = irq_global_enable && rxIrqEv;
  wire setTx = irq_global_enable && txIrqEv;
  // block end on the last transfer of a direction
  wire rxEnd = dmaRxReq && rxCount == 17'h00001;
  wire txEnd = dmaTxReq && txCount == 17'h00001;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prioPend <= i2c_event_pkg::RESET_PRIO_PEND;
      mask <= i2c_event_pkg::RESET_ZERO;
    end else begin
      if (wrPp) begin
        prioPend <= regWdata;
      end
      if (setErr) begin
        prioPend[i2c_event_pkg::PP_ERRP] <= 1'b1;
      end
      if (setRx) begin
        prioPend[i2c_event_pkg::PP_RXP] <= 1'b1;
      end
      if (setTx) begin
        prioPend[i2c_event_pkg::PP_TXP] <= 1'b1;
      end
      if (wrMk) begin
        mask <= regWdata;
      end
      // block end pending, no global enable
      if (rxEnd) begin
        mask[i2c_event_pkg::MK_REOB] <= 1'b1;
        mask[i2c_event_pkg::MK_RXDMA] <= 1'b0;
      end
      if (txEnd) begin
        mask[i2c_event_pkg::MK_TEOB] <= 1'b1;
        mask[i2c_event_pkg::MK_TXDMA] <= 1'b0;
      end
    end
  end

  // dma counters and addresses
  function automatic logic [16:0] clamp_count(input logic [7:0] v, input logic rf);
    logic [16:0] lim;
    lim = rf ? i2c_event_pkg::MAX_REGFILE : i2c_event_pkg::MAX_MEMORY;
    clamp_count = ({9'h000, v} > lim) ? lim : {9'h000, v};
  endfunction : clamp_count

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxCount <= 17'h00000;
      txCount <= 17'h00000;
      rxAddr <= 16'h0000;
      txAddr <= 16'h0000;
    end else begin
      if (regWrite && regAddr == i2c_event_pkg::OFS_RX_COUNT) begin
        rxCount <= clamp_count(regWdata, rxRegFile);
      end else if (dmaRxReq) begin
        rxCount <= rxCount - 17'h00001;
        rxAddr <= rxAddr + 16'h0001;
      end
      if (regWrite && regAddr == i2c_event_pkg::OFS_TX_COUNT) begin
        txCount <= clamp_count(regWdata, txRegFile);
      end else if (dmaTxReq) begin
        txCount <= txCount - 17'h00001;
        txAddr <= txAddr + 16'h0001;
      end
      if (regWrite && regAddr == i2c_event_pkg::OFS_RX_ADDR) begin
        rxAddr <= {8'h00, regWdata};
      end
      if (regWrite && regAddr == i2c_event_pkg::OFS_TX_ADDR) begin
        txAddr <= {8'h00, regWdata};
      end
    end
  end

  wire dmaPause = prioPend[i2c_event_pkg::PP_HOLD] && prioPend[i2c_event_pkg::PP_ERRP];
  // dma per direction only when enabled
  assign dmaRxReq = mask[i2c_event_pkg::MK_RXDMA] && rxSource && !dmaPause && rxCount != 17'h00000;
  assign dmaTxReq = mask[i2c_event_pkg::MK_TXDMA] && txSource && !dmaPause && txCount != 17'h00000;

  // request arbitration
  wire [2:0] level = prioPend[2:0];
  // keep requesting while pending and masked
  // flag-based error requests need the global enable
  wire reqErr = irq_global_enable && (prioPend[i2c_event_pkg::PP_ERRP] || errFlags) && mask[i2c_event_pkg::MK_ERRM];
  wire reqRx = (prioPend[i2c_event_pkg::PP_RXP] || mask[i2c_event_pkg::MK_REOB]) && mask[i2c_event_pkg::MK_RXM];
  wire reqTx = (prioPend[i2c_event_pkg::PP_TXP] || mask[i2c_event_pkg::MK_TEOB]) && mask[i2c_event_pkg::MK_TXM];
  wire [2:0] lowBits = reqErr ? i2c_event_pkg::VEC_ERROR : reqRx ? i2c_event_pkg::VEC_RX : i2c_event_pkg::VEC_TX;
  wire anyReq = (reqErr || reqRx || reqTx) && level != i2c_event_pkg::PRIO_OFF;

  // interrupt outputs registered
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irqReq <= 1'b0;
      irqVector <= 8'h00;
      irqLevel <= i2c_event_pkg::PRIO_OFF;
    end else begin
      irqReq <= anyReq;
      irqVector <= {vectorHigh[7:3], lowBits};
      irqLevel <= level;
    end
  end

  // read mux
  always_comb begin
    rdata = 8'h00;
    case (regAddr)
      i2c_event_pkg::OFS_STATUS_ONE: rdata = {summary, headerSent, sending, 1'b0, byteDone, 1'b0, startSent, addrMatch};
      i2c_event_pkg::OFS_STATUS_TWO: rdata = {2'h0, addrSent, noAck, halt, arbLost, busError, clockLow};
      i2c_event_pkg::OFS_DATA: rdata = dataReg;
      i2c_event_pkg::OFS_CONTROL: rdata = control;
      i2c_event_pkg::OFS_VECTOR: rdata = vectorHigh;
      i2c_event_pkg::OFS_PRIO_PEND: rdata = prioPend;
      i2c_event_pkg::OFS_MASK: rdata = mask;
      i2c_event_pkg::OFS_RX_COUNT: rdata = rxCount[7:0];
      i2c_event_pkg::OFS_TX_COUNT: rdata = txCount[7:0];
      i2c_event_pkg::OFS_RX_ADDR: rdata = rxAddr[7:0];
      i2c_event_pkg::OFS_TX_ADDR: rdata = txAddr[7:0];
      default: rdata = 8'h00;
    endcase
  end

  // read data one cycle later, data to dma registered
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
      dataOut <= 8'h00;
    end else begin
      regRdata <= regRead ? rdata : 8'h00;
      dataOut <= dataReg;
    end
  end

  // checks
  // match clears on read
  chk_match_clear: assert property (@(posedge clock) disable iff (!resetn)
    rdS1 && !evAddrMatch |=> !addrMatch) else $error("match not cleared");
  chk_halt_clear: assert property (@(posedge clock) disable iff (!resetn)
    rdS2 && !evHalt |=> !halt) else $error("halt not cleared");
  chk_summary_or: assert property (@(posedge clock) disable iff (!resetn)
    summary == (errFlags || byteDone)) else $error("summary mismatch");
  chk_dma_pause: assert property (@(posedge clock) disable iff (!resetn)
    dmaPause |-> !dmaRxReq && !dmaTxReq) else $error("dma not paused");
  chk_level_off: assert property (@(posedge clock) disable iff (!resetn)
    level == 3'h7 |=> !irqReq) else $error("request at lowest level");
  chk_vector_bits: assert property (@(posedge clock) disable iff (!resetn)
    reqErr |=> irqVector[2:0] == 3'h2) else $error("bad error vector");
  chk_err_forced: assert property (@(posedge clock) disable iff (!resetn)
    errFlags |=> prioPend[i2c_event_pkg::PP_ERRP]) else $error("error pending not set");
  chk_block_end: assert property (@(posedge clock) disable iff (!resetn)
    rxEnd |=> mask[5]) else $error("block end not pending");
  chk_start_hold: assert property (@(posedge clock) disable iff (!resetn)
    startSent && !wrDr |=> startSent) else $error("start flag lost");
  chk_dma_clear: assert property (@(posedge clock) disable iff (!resetn)
    dmaRxDone && !evByteRx && !evByteTx && !evNoAck |=> !byteDone) else $error("byte done not cleared by dma");
  chk_release_hide: assert property (@(posedge clock) disable iff (!resetn)
    hideHalt && evHalt && !halt |=> !halt) else $error("halt seen after release");
  chk_dma_suppress: assert property (@(posedge clock) disable iff (!resetn)
    mask[i2c_event_pkg::MK_RXDMA] && !wrPp |=> !$rose(prioPend[i2c_event_pkg::PP_RXP])) else $error("rx pending with dma");
  chk_rx_persist: assert property (@(posedge clock) disable iff (!resetn)
    prioPend[i2c_event_pkg::PP_RXP] && mask[i2c_event_pkg::MK_RXM] && level != i2c_event_pkg::PRIO_OFF |=> irqReq)
    else $error("rx request dropped");
  // no receive or transmit pending without global enable
  chk_ite_gate: assert property (@(posedge clock) disable iff (!resetn)
    !irq_global_enable && !wrPp |=> !$rose(prioPend[i2c_event_pkg::PP_RXP]) && !$rose(prioPend[i2c_event_pkg::PP_TXP]))
    else $error("data pending without global enable");
  chk_count_step: assert property (@(posedge clock) disable iff (!resetn)
    dmaRxReq && !(regWrite && regAddr == i2c_event_pkg::OFS_RX_COUNT) |=> rxCount == $past(rxCount) - 17'h00001)
    else $error("rx count not decremented");
  chk_tx_block_end: assert property (@(posedge clock) disable iff (!resetn)
    txEnd |=> mask[i2c_event_pkg::MK_TEOB] && !mask[i2c_event_pkg::MK_TXDMA]) else $error("tx block end not pending");
  cov_rx_irq: cover property (@(posedge clock) disable iff (!resetn) setRx ##1 irqReq);
  cov_dma_end: cover property (@(posedge clock) disable iff (!resetn) txEnd);
  cov_err_irq: cover property (@(posedge clock) disable iff (!resetn) reqErr ##1 irqReq);
endmodule : i2c_event_irq_dma_logic

// file: dma_channel_model.sv
// on-chip dma channel model answering the block's transfer requests
module dma_channel_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // transfer requests from the block
  input  wire logic       dmaRxReq,
  input  wire logic       dmaTxReq,
  // answers to the block
  output logic            dmaRxDone,
  output logic            dmaTxDone,
  output logic      [7:0] dataIn
);
  timeunit 1ns;
  timeprecision 100ps;

  // completion answers
  // each request cycle moves one word and reports completion at once
  assign dmaRxDone = dmaRxReq;
  assign dmaTxDone = dmaTxReq;

  // word per transfer
  // received word changes every cycle so a stale value never passes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dataIn <= 8'h3C;
    end else begin
      dataIn <= dataIn + 8'h11;
    end
  end
endmodule : dma_channel_model

// file: i2c_event_irq_dma_logic_test.sv
// self-checking bench for the event, interrupt and dma request logic
module i2c_event_irq_dma_logic_test;
  timeunit 1ns;
  timeprecision 100ps;

  // clock, reset and register port
  logic        clock;
  logic        resetn;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata;
  logic        regWrite;
  logic        regRead;
  logic [7:0]  regRdata;
  // events, dma and interrupt side
  logic [10:0] evBits;
  logic        sendingSide;
  logic        rxRegFile;
  logic        txRegFile;
  logic        dmaRxReq;
  logic        dmaTxReq;
  logic        dmaRxDone;
  logic        dmaTxDone;
  logic        irqReq;
  logic [7:0]  dataOut;
  logic [7:0]  dataIn;
  logic [7:0]  irqVector;
  logic [2:0]  irqLevel;
  int          badCount;
  int          testsRun;

  // event pulse bits
  localparam logic [10:0] E_AM = 11'h001, E_RX = 11'h002, E_TX = 11'h004, E_NA = 11'h008;
  localparam logic [10:0] E_HALT = 11'h010, E_START = 11'h020, E_ASENT = 11'h040, E_HDR = 11'h080;
  localparam logic [10:0] E_ARB = 11'h100, E_BUS_ERROR_FLAG = 11'h200, E_CLK = 11'h400;
  localparam logic [4:0]  VEC_HI = 5'h15;

  i2c_event_irq_dma_logic i_i2c_event_irq_dma_logic (
    .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .evAddrMatch(evBits[0]), .evByteRx(evBits[1]),
    .evByteTx(evBits[2]), .evNoAck(evBits[3]), .evHalt(evBits[4]), .evStartSent(evBits[5]),
    .evAddrSent(evBits[6]), .evHeaderSent(evBits[7]), .evArbLost(evBits[8]), .evBusError(evBits[9]),
    .evClockLow(evBits[10]), .sendingSide(sendingSide), .dmaRxDone(dmaRxDone), .dmaTxDone(dmaTxDone),
    .rxRegFile(rxRegFile), .txRegFile(txRegFile), .dmaRxReq(dmaRxReq), .dmaTxReq(dmaTxReq),
    .dataOut(dataOut), .dataIn(dataIn), .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel)
  );

  dma_channel_model i_dma_channel_model (
    .clock(clock), .resetn(resetn), .dmaRxReq(dmaRxReq), .dmaTxReq(dmaTxReq),
    .dmaRxDone(dmaRxDone), .dmaTxDone(dmaTxDone), .dataIn(dataIn)
  );

  // clock generator
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // compare and count
  task automatic chk(input logic [7:0] gotv, input logic [7:0] exp);
    testsRun++;
    if (gotv !== exp) begin
      badCount++;
      $display("[ERR] %0t got %h expected %h", $time, gotv, exp);
    end
  endtask : chk

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  // one-cycle register read, data judged in the following cycle
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask : rdc

  // one-cycle event pulse from the shifter
  task automatic ev(input logic [10:0] v);
    @(posedge clock);
    evBits <= v;
    @(posedge clock);
    evBits <= '0;
  endtask : ev

  // bounded wait for the interrupt request level
  task automatic waitIrq(input logic lvl);
    int n = 0;
    #1;
    while (irqReq !== lvl && n < 10) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk({7'h00, irqReq}, {7'h00, lvl});
  endtask : waitIrq

  // reset values and an unmapped place
  task automatic tReset;
    rdc(i2c_event_pkg::OFS_PRIO_PEND, i2c_event_pkg::RESET_PRIO_PEND);
    rdc(i2c_event_pkg::OFS_MASK, 8'h00);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h00);
    rdc(4'hF, 8'h00);
    chk({5'h00, irqLevel}, {5'h00, i2c_event_pkg::PRIO_OFF});
  endtask : tReset

  // received byte interrupt, persistence and the disabling level
  task automatic tRxIrq;
    wr(i2c_event_pkg::OFS_VECTOR, {VEC_HI, 3'h0});
    wr(i2c_event_pkg::OFS_CONTROL, 8'h01);
    wr(i2c_event_pkg::OFS_MASK, 8'h07);
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'h00);
    ev(E_RX);
    waitIrq(1'b1);
    chk(irqVector, {VEC_HI, i2c_event_pkg::VEC_RX});
    chk({5'h00, irqLevel}, 8'h00);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h88);
    wr(i2c_event_pkg::OFS_DATA, 8'hC3);
    rdc(i2c_event_pkg::OFS_DATA, 8'hC3);
    chk(dataOut, 8'hC3);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h00);
    waitIrq(1'b1);
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'h27);
    waitIrq(1'b0);
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'h20);
    waitIrq(1'b1);
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'h00);
    waitIrq(1'b0);
  endtask : tRxIrq

  // error source outranks ready to transmit, start flag cleared by data write
  task automatic tPrio;
    sendingSide <= 1'b1;
    ev(E_TX | E_START);
    waitIrq(1'b1);
    chk(irqVector, {VEC_HI, i2c_event_pkg::VEC_ERROR});
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'hAA);
    wr(i2c_event_pkg::OFS_DATA, 8'h5A);
    @(posedge clock);
    #1;
    chk(dataOut, 8'h5A);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h20);
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'h10);
    repeat (3) @(posedge clock);
    #1;
    chk(irqVector, {VEC_HI, i2c_event_pkg::VEC_TX});
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'h00);
    waitIrq(1'b0);
    sendingSide <= 1'b0;
  endtask : tPrio

  // every error event except start sent, forced error pending, line release and address match
  task automatic tErrors;
    wr(i2c_event_pkg::OFS_CONTROL, 8'h00);
    ev(E_NA | E_HALT | E_ASENT | E_HDR | E_ARB | E_BUS_ERROR_FLAG | E_CLK);
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'h00);
    rdc(i2c_event_pkg::OFS_PRIO_PEND, 8'h40);
    chk({7'h00, irqReq}, 8'h00);
    rdc(i2c_event_pkg::OFS_STATUS_TWO, 8'h3F);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'hC8);
    wr(i2c_event_pkg::OFS_CONTROL, 8'h02);
    wr(i2c_event_pkg::OFS_CONTROL, 8'h00);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'hC0);
    wr(i2c_event_pkg::OFS_DATA, 8'hFF);
    rdc(i2c_event_pkg::OFS_STATUS_TWO, 8'h00);
    ev(E_HALT);
    rdc(i2c_event_pkg::OFS_STATUS_TWO, 8'h00);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h00);
    ev(E_AM);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h81);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h00);
    ev(E_HALT);
    rdc(i2c_event_pkg::OFS_STATUS_TWO, 8'h08);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h00);
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'h00);
    rdc(i2c_event_pkg::OFS_PRIO_PEND, 8'h00);
  endtask : tErrors

  // receive dma held by error pending, then two transfers to block end
  task automatic tDma;
    wr(i2c_event_pkg::OFS_RX_COUNT, 8'hFF);
    rdc(i2c_event_pkg::OFS_RX_COUNT, i2c_event_pkg::MAX_REGFILE[7:0]);
    wr(i2c_event_pkg::OFS_RX_COUNT, 8'h02);
    wr(i2c_event_pkg::OFS_RX_ADDR, 8'h10);
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'hC0);
    wr(i2c_event_pkg::OFS_MASK, 8'h82);
    ev(E_RX);
    repeat (4) @(posedge clock);
    rdc(i2c_event_pkg::OFS_RX_COUNT, 8'h02);
    chk({7'h00, dmaRxReq}, 8'h00);
    chk({7'h00, irqReq}, 8'h00);
    wr(i2c_event_pkg::OFS_PRIO_PEND, 8'h80);
    repeat (4) @(posedge clock);
    rdc(i2c_event_pkg::OFS_RX_COUNT, 8'h01);
    rdc(i2c_event_pkg::OFS_RX_ADDR, 8'h11);
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h00);
    ev(E_RX);
    repeat (4) @(posedge clock);
    rdc(i2c_event_pkg::OFS_RX_COUNT, 8'h00);
    rdc(i2c_event_pkg::OFS_MASK, 8'h22);
    waitIrq(1'b1);
    chk(irqVector, {VEC_HI, i2c_event_pkg::VEC_RX});
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h00);
    wr(i2c_event_pkg::OFS_MASK, 8'h02);
    waitIrq(1'b0);
  endtask : tDma

  // transmit dma to block end on a memory target
  task automatic tDmaTx;
    sendingSide <= 1'b1;
    wr(i2c_event_pkg::OFS_TX_COUNT, 8'hFF);
    rdc(i2c_event_pkg::OFS_TX_COUNT, 8'hFF);
    wr(i2c_event_pkg::OFS_TX_COUNT, 8'h01);
    wr(i2c_event_pkg::OFS_MASK, 8'h41);
    ev(E_TX);
    #1;
    chk({7'h00, dmaTxReq}, 8'h01);
    @(posedge clock);
    #1;
    chk({7'h00, dmaTxReq}, 8'h00);
    rdc(i2c_event_pkg::OFS_TX_COUNT, 8'h00);
    rdc(i2c_event_pkg::OFS_MASK, 8'h11);
    waitIrq(1'b1);
    chk(irqVector, {VEC_HI, i2c_event_pkg::VEC_TX});
    rdc(i2c_event_pkg::OFS_STATUS_ONE, 8'h20);
    wr(i2c_event_pkg::OFS_MASK, 8'h00);
    waitIrq(1'b0);
    sendingSide <= 1'b0;
  endtask : tDmaTx

  // verdict and end of run
  task automatic reportAndStop;
    if (badCount == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : reportAndStop

  // main sequence
  initial begin
    badCount = 0;
    testsRun = 0;
    resetn = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    evBits = '0;
    sendingSide = 1'b0;
    rxRegFile = 1'b1;
    txRegFile = 1'b0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    tReset();
    tRxIrq();
    tPrio();
    tErrors();
    tDma();
    tDmaTx();
    reportAndStop();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock);
    badCount++;
    reportAndStop();
  end
endmodule : i2c_event_irq_dma_logic_test
